// file: rtl/plm_pkg.sv
package plm_pkg;
   localparam int NUM_PT = 137;
   localparam int NUM_OMC = 16;
   localparam int GRP = 8;
   localparam int NUM_IMC = 20;
   localparam int NUM_IMC_GRP = 5;
   localparam int IMC_GRP_W = 4;
   // layout of the and-array input vector
   localparam int IN_ADDR = 0;
   localparam int IN_PSEN = 16;
   localparam int IN_RD = 17;
   localparam int IN_WR = 18;
   localparam int IN_ALE = 19;
   localparam int IN_RST = 20;
   localparam int IN_PDN = 21;
   localparam int IN_IMC = 22;
   localparam int IN_PD = 42;
   localparam int IN_PAGE = 44;
   localparam int IN_FB = 52;
   localparam int IN_READY = 68;
   localparam int NUM_IN = 69;
   // product term numbering
   localparam int PT_FS = 0;
   localparam int NUM_FS = 8;
   localparam int FS_TERMS = 3;
   localparam int PT_CSB = 24;
   localparam int NUM_CSB = 4;
   localparam int CSB_TERMS = 3;
   localparam int PT_SRAM = 36;
   localparam int SRAM_TERMS = 2;
   localparam int PT_REGSP = 38;
   localparam int PT_PSEL = 39;
   localparam int NUM_PSEL = 2;
   localparam int PT_ECS = 41;
   localparam int NUM_ECS = 2;
   localparam int PT_AB = 43;
   localparam int AB_TERMS = 3;
   localparam int PT_BC = 67;
   localparam int BC_TERMS = 4;
   localparam int PT_POOL = 99;
   localparam int BORROW_SLOTS = 6;
   localparam int BORROW_AB = 6;
   localparam int BORROW_BC_LO = 5;
   localparam int BORROW_BC_HI = 6;
   localparam int BC_HI_FIRST = 4;
   localparam int PD_CLK_BIT = 1;
   localparam logic [4:0] NO_OWNER = 5'h1F;
   localparam logic [7:0] PORT_C_CELLS = 8'h9C;
   localparam logic [7:0] MASK_RESET = 8'h00;
   // register space offsets, low address byte
   localparam logic [7:0] REG_IMC_A = 8'h0A;
   localparam logic [7:0] REG_IMC_B = 8'h0B;
   localparam logic [7:0] REG_IMC_C = 8'h18;
   localparam logic [7:0] REG_OMC_AB = 8'h20;
   localparam logic [7:0] REG_OMC_BC = 8'h21;
   localparam logic [7:0] REG_MASK_AB = 8'h22;
   localparam logic [7:0] REG_MASK_BC = 8'h23;

   typedef enum logic [1:0] {FF_D, FF_T, FF_JK, FF_SR} ff_type_e;
   typedef enum logic [1:0] {IMC_PASS, IMC_LATCH, IMC_REG} imc_mode_e;
   typedef enum logic {LOAD_EDGE, LOAD_LEVEL} load_mode_e;
   typedef logic [7:0] pt_idx_t;

   typedef struct packed {
      logic used;
      logic [NUM_IN-1:0] true_m;
      logic [NUM_IN-1:0] comp_m;
   } pt_cfg_s;

   typedef struct packed {
      ff_type_e ff;
      logic invert;
      logic registered;
      logic clk_from_pin;
      logic node_only;
      logic oe_defined;
      logic alt_port;
      logic pre_en;
      logic [1:0] clr_en;
      logic [BORROW_SLOTS-1:0] borrow_en;
      pt_idx_t [BORROW_SLOTS-1:0] borrow_idx;
      pt_idx_t clk_pt;
      pt_idx_t pre_pt;
      pt_idx_t clr_pt0;
      pt_idx_t clr_pt1;
      pt_idx_t oe_pt;
   } omc_cfg_s;

   typedef struct packed {
      imc_mode_e mode;
      logic clk_from_ale;
      pt_idx_t en_pt;
   } imc_cfg_s;
endpackage

// file: rtl/omc_cell.sv
`timescale 1ns/1ps
module omc_cell (
   input wire logic clk_in,
   input wire logic rstn_in,
   input plm_pkg::ff_type_e ff_in,
   input wire logic registered_in,
   input wire logic x_in,
   input wire logic k_in,
   input wire logic clk_ev_in,
   input wire logic pre_in,
   input wire logic clr_in,
   input wire logic load_in,
   input wire logic load_data_in,
   output logic q_out,
   output logic sel_out
);
   // processor load first, then clear, preset, own clock
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         q_out <= 1'b0;
      end else if (load_in) begin
         q_out <= load_data_in;
      end else if (clr_in) begin
         q_out <= 1'b0;
      end else if (pre_in) begin
         q_out <= 1'b1;
      end else if (clk_ev_in) begin
         unique case (ff_in)
            plm_pkg::FF_D: q_out <= x_in;
            plm_pkg::FF_T: q_out <= q_out ^ x_in;
            plm_pkg::FF_JK: q_out <= (x_in & ~q_out) | (~k_in & q_out);
            plm_pkg::FF_SR: q_out <= x_in ? 1'b1 : (k_in ? 1'b0 : q_out);
         endcase
      end
   end

   assign sel_out = registered_in ? q_out : x_in;
endmodule // omc_cell

// file: rtl/imc_group.sv
`timescale 1ns/1ps
module imc_group (
   input wire logic clk_in,
   input wire logic rstn_in,
   input plm_pkg::imc_cfg_s cfg_in,
   input wire logic [plm_pkg::IMC_GRP_W-1:0] pin_in,
   input wire logic ale_in,
   input wire logic pt_in,
   output logic [plm_pkg::IMC_GRP_W-1:0] q_out
);
   logic en;
   logic en_d_r;
   logic [plm_pkg::IMC_GRP_W-1:0] hold_r;

   assign en = cfg_in.clk_from_ale ? ale_in : pt_in;

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         en_d_r <= 1'b0;
      end else begin
         en_d_r <= en;
      end
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         hold_r <= '0;
      end else if (cfg_in.mode == plm_pkg::IMC_LATCH && en) begin
         hold_r <= pin_in;
      end else if (cfg_in.mode == plm_pkg::IMC_REG && en && !en_d_r) begin
         hold_r <= pin_in;
      end
   end

   always_comb begin
      unique case (cfg_in.mode)
         plm_pkg::IMC_PASS: q_out = pin_in;
         plm_pkg::IMC_LATCH: q_out = en ? pin_in : hold_r;
         plm_pkg::IMC_REG: q_out = hold_r;
         default: q_out = pin_in;
      endcase
   end
endmodule // imc_group

// file: rtl/prog_logic.sv
`timescale 1ns/1ps
module prog_logic (
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic cfg_we_in,
   input plm_pkg::pt_idx_t cfg_idx_in,
   input plm_pkg::pt_cfg_s cfg_pt_in,
   input plm_pkg::omc_cfg_s [plm_pkg::NUM_OMC-1:0] omc_cfg_in,
   input plm_pkg::imc_cfg_s [plm_pkg::NUM_IMC_GRP-1:0] imc_cfg_in,
   input plm_pkg::load_mode_e load_mode_in,
   input wire logic [15:0] core_addr_in,
   input wire logic [7:0] core_wdata_in,
   input wire logic core_psen_in,
   input wire logic core_rd_in,
   input wire logic core_wr_in,
   input wire logic core_ale_in,
   input wire logic core_rst_in,
   input wire logic core_pdn_in,
   input wire logic [7:0] page_in,
   input wire logic flash_ready_in,
   input wire logic [7:0] port_a_in,
   input wire logic [7:0] port_b_in,
   input wire logic [7:0] port_c_in,
   input wire logic [2:0] port_d_in,
   input wire logic [7:0] dir_a_in,
   input wire logic [7:0] dir_b_in,
   input wire logic [7:0] dir_c_in,
   output logic [7:0] core_rdata_out,
   output logic core_rvalid_out,
   output logic [7:0] port_a_out,
   output logic [7:0] port_a_oe_out,
   output logic [7:0] port_b_out,
   output logic [7:0] port_b_oe_out,
   output logic [7:0] port_c_out,
   output logic [7:0] port_c_oe_out,
   output logic [7:0] primary_flash_sector_selects_out,
   output logic [3:0] secondary_flash_sector_selects_out,
   output logic static_ram_select_out,
   output logic register_space_select_out,
   output logic [1:0] peripheral_selects_out,
   output logic [1:0] external_chip_selects_out
);
   localparam int NPT = plm_pkg::NUM_PT;
   localparam int NOMC = plm_pkg::NUM_OMC;

   plm_pkg::pt_cfg_s pt_mem_r [NPT];
   logic [NPT-1:0] pt;
   logic [plm_pkg::NUM_IN-1:0] in_vec;
   logic [4:0] owner [NPT];
   logic [7:0] a_s1_r, a_s2_r, b_s1_r, b_s2_r, c_s1_r, c_s2_r;
   logic [2:0] d_s1_r, d_s2_r;
   logic [plm_pkg::NUM_IMC-1:0] imc_q;
   logic [NOMC-1:0] cell_q, cell_sel, fb_r, clk_src, clk_src_d_r, load_vec, oe_term;
   logic [7:0] mask_ab_r, mask_bc_r, data_d_r, load_data;
   logic wr_d_r, hit_ab_d_r, hit_bc_d_r, regsel, hit_ab, hit_bc, strobe_ab, strobe_bc;
   logic [7:0] a_nxt, a_oe_nxt, b_nxt, b_oe_nxt, c_nxt, c_oe_nxt;
   logic [7:0] fs_nxt;
   logic [3:0] csb_nxt;

   function automatic logic term_at(input logic [NPT-1:0] v, input plm_pkg::pt_idx_t i);
      term_at = (int'(i) < NPT) ? v[i] : 1'b0;
   endfunction

   // product term programming store
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         for (int p = 0; p < NPT; p++) begin
            pt_mem_r[p] <= '0;
         end
      end else if (cfg_we_in && int'(cfg_idx_in) < NPT) begin
         pt_mem_r[cfg_idx_in] <= cfg_pt_in;
      end
   end

   // pins cross in through two flip-flops
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         {a_s1_r, a_s2_r, b_s1_r, b_s2_r, c_s1_r, c_s2_r} <= '0;
         {d_s1_r, d_s2_r} <= '0;
      end else begin
         {a_s1_r, b_s1_r, c_s1_r, d_s1_r} <= {port_a_in, port_b_in, port_c_in, port_d_in};
         {a_s2_r, b_s2_r, c_s2_r, d_s2_r} <= {a_s1_r, b_s1_r, c_s1_r, d_s1_r};
      end
   end

   always_comb begin
      in_vec = '0;
      in_vec[plm_pkg::IN_ADDR +: 16] = core_addr_in;
      in_vec[plm_pkg::IN_PSEN] = core_psen_in;
      in_vec[plm_pkg::IN_RD] = core_rd_in;
      in_vec[plm_pkg::IN_WR] = core_wr_in;
      in_vec[plm_pkg::IN_ALE] = core_ale_in;
      in_vec[plm_pkg::IN_RST] = core_rst_in;
      in_vec[plm_pkg::IN_PDN] = core_pdn_in;
      in_vec[plm_pkg::IN_IMC +: plm_pkg::NUM_IMC] = imc_q;
      in_vec[plm_pkg::IN_PD +: 2] = d_s2_r[2:1];
      in_vec[plm_pkg::IN_PAGE +: 8] = page_in;
      in_vec[plm_pkg::IN_FB +: NOMC] = fb_r;
      in_vec[plm_pkg::IN_READY] = flash_ready_in;
   end

   // and array: a term is true when every selected literal holds
   always_comb begin
      for (int p = 0; p < NPT; p++) begin
         pt[p] = pt_mem_r[p].used & (&((in_vec | ~pt_mem_r[p].true_m)
                 & (~in_vec | ~pt_mem_r[p].comp_m)));
      end
   end

   // decode array
   always_comb begin
      fs_nxt = '0;
      csb_nxt = '0;
      for (int i = 0; i < plm_pkg::NUM_FS; i++) begin
         fs_nxt[i] = |pt[plm_pkg::PT_FS + plm_pkg::FS_TERMS*i +: plm_pkg::FS_TERMS];
      end
      for (int i = 0; i < plm_pkg::NUM_CSB; i++) begin
         csb_nxt[i] = |pt[plm_pkg::PT_CSB + plm_pkg::CSB_TERMS*i +: plm_pkg::CSB_TERMS];
      end
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         primary_flash_sector_selects_out <= '0;
         secondary_flash_sector_selects_out <= '0;
         static_ram_select_out <= 1'b0;
         register_space_select_out <= 1'b0;
         peripheral_selects_out <= '0;
         external_chip_selects_out <= '0;
      end else begin
         primary_flash_sector_selects_out <= fs_nxt;
         secondary_flash_sector_selects_out <= csb_nxt;
         static_ram_select_out <= |pt[plm_pkg::PT_SRAM +: plm_pkg::SRAM_TERMS];
         register_space_select_out <= pt[plm_pkg::PT_REGSP];
         peripheral_selects_out <= pt[plm_pkg::PT_PSEL +: plm_pkg::NUM_PSEL];
         external_chip_selects_out <= pt[plm_pkg::PT_ECS +: plm_pkg::NUM_ECS];
      end
   end

   // a pool term belongs to the lowest cell that claims it
   always_comb begin
      for (int p = 0; p < NPT; p++) begin
         owner[p] = plm_pkg::NO_OWNER;
      end
      for (int c = NOMC - 1; c >= 0; c--) begin
         for (int s = 0; s < plm_pkg::BORROW_SLOTS; s++) begin
            if (omc_cfg_in[c].borrow_en[s] && int'(omc_cfg_in[c].borrow_idx[s]) >= plm_pkg::PT_POOL
                && int'(omc_cfg_in[c].borrow_idx[s]) < NPT) begin
               owner[omc_cfg_in[c].borrow_idx[s]] = 5'(c);
            end
         end
      end
   end

   // register space access
   assign regsel = pt[plm_pkg::PT_REGSP];
   assign hit_ab = regsel && core_addr_in[7:0] == plm_pkg::REG_OMC_AB;
   assign hit_bc = regsel && core_addr_in[7:0] == plm_pkg::REG_OMC_BC;
   assign strobe_ab = (load_mode_in == plm_pkg::LOAD_LEVEL) ? (core_wr_in && hit_ab)
                      : (wr_d_r && !core_wr_in && hit_ab_d_r);
   assign strobe_bc = (load_mode_in == plm_pkg::LOAD_LEVEL) ? (core_wr_in && hit_bc)
                      : (wr_d_r && !core_wr_in && hit_bc_d_r);
   assign load_data = (load_mode_in == plm_pkg::LOAD_LEVEL) ? core_wdata_in : data_d_r;
   assign load_vec = {{8{strobe_bc}} & ~mask_bc_r, {8{strobe_ab}} & ~mask_ab_r};

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         wr_d_r <= 1'b0;
         hit_ab_d_r <= 1'b0;
         hit_bc_d_r <= 1'b0;
         data_d_r <= '0;
      end else begin
         wr_d_r <= core_wr_in;
         hit_ab_d_r <= hit_ab && core_wr_in;
         hit_bc_d_r <= hit_bc && core_wr_in;
         data_d_r <= core_wdata_in;
      end
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         mask_ab_r <= plm_pkg::MASK_RESET;
         mask_bc_r <= plm_pkg::MASK_RESET;
      end else if (core_wr_in && regsel) begin
         if (core_addr_in[7:0] == plm_pkg::REG_MASK_AB) mask_ab_r <= core_wdata_in;
         if (core_addr_in[7:0] == plm_pkg::REG_MASK_BC) mask_bc_r <= core_wdata_in;
      end
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         core_rdata_out <= '0;
         core_rvalid_out <= 1'b0;
      end else begin
         core_rvalid_out <= core_rd_in && regsel;
         if (core_rd_in && regsel) begin
            unique case (core_addr_in[7:0])
               plm_pkg::REG_IMC_A: core_rdata_out <= imc_q[7:0];
               plm_pkg::REG_IMC_B: core_rdata_out <= imc_q[15:8];
               plm_pkg::REG_IMC_C: core_rdata_out <= {imc_q[19], 2'b00, imc_q[18:16], 2'b00};
               plm_pkg::REG_OMC_AB: core_rdata_out <= cell_q[7:0];
               plm_pkg::REG_OMC_BC: core_rdata_out <= cell_q[15:8];
               plm_pkg::REG_MASK_AB: core_rdata_out <= mask_ab_r;
               plm_pkg::REG_MASK_BC: core_rdata_out <= mask_bc_r;
               default: core_rdata_out <= '0;
            endcase
         end
      end
   end

   // input cells, four per shared enable
   for (genvar g = 0; g < plm_pkg::NUM_IMC_GRP; g++) begin : g_imc
      logic [3:0] pins;
      if (g < 2) begin : g_a
         assign pins = a_s2_r[4*g +: 4];
      end else if (g < 4) begin : g_b
         assign pins = b_s2_r[4*(g-2) +: 4];
      end else begin : g_c
         assign pins = {c_s2_r[7], c_s2_r[4:2]};
      end
      imc_group u_imc (
         .clk_in(clk_in),
         .rstn_in(rstn_in),
         .cfg_in(imc_cfg_in[g]),
         .pin_in(pins),
         .ale_in(core_ale_in),
         .pt_in(term_at(pt, imc_cfg_in[g].en_pt)),
         .q_out(imc_q[4*g +: 4])
      );
   end

   // output cells
   for (genvar c = 0; c < NOMC; c++) begin : g_omc
      localparam int BASE = (c < 8) ? plm_pkg::PT_AB + plm_pkg::AB_TERMS*c
                                    : plm_pkg::PT_BC + plm_pkg::BC_TERMS*(c-8);
      localparam int NAT = (c < 8) ? plm_pkg::AB_TERMS : plm_pkg::BC_TERMS;
      localparam int LIM = (c < 8) ? plm_pkg::BORROW_AB
                         : ((c - 8 < plm_pkg::BC_HI_FIRST) ? plm_pkg::BORROW_BC_LO
                                                           : plm_pkg::BORROW_BC_HI);
      logic sum, x, pre, clr;
      logic jk_sr;
      assign jk_sr = omc_cfg_in[c].ff == plm_pkg::FF_JK || omc_cfg_in[c].ff == plm_pkg::FF_SR;
      always_comb begin
         sum = 1'b0;
         for (int k = 0; k < NAT; k++) begin
            if (k > 0 || !jk_sr) sum = sum | pt[BASE + k];
         end
         for (int s = 0; s < LIM; s++) begin
            if (omc_cfg_in[c].borrow_en[s] && int'(omc_cfg_in[c].borrow_idx[s]) < NPT
                && owner[omc_cfg_in[c].borrow_idx[s]] == 5'(c)) begin
               sum = sum | pt[omc_cfg_in[c].borrow_idx[s]];
            end
         end
      end
      assign x = sum ^ omc_cfg_in[c].invert;
      assign pre = omc_cfg_in[c].pre_en & term_at(pt, omc_cfg_in[c].pre_pt);
      assign clr = (omc_cfg_in[c].clr_en[0] & term_at(pt, omc_cfg_in[c].clr_pt0))
                 | (omc_cfg_in[c].clr_en[1] & term_at(pt, omc_cfg_in[c].clr_pt1));
      assign clk_src[c] = omc_cfg_in[c].clk_from_pin ? d_s2_r[plm_pkg::PD_CLK_BIT]
                          : term_at(pt, omc_cfg_in[c].clk_pt);
      assign oe_term[c] = term_at(pt, omc_cfg_in[c].oe_pt);
      omc_cell u_cell (
         .clk_in(clk_in),
         .rstn_in(rstn_in),
         .ff_in(omc_cfg_in[c].ff),
         .registered_in(omc_cfg_in[c].registered),
         .x_in(x),
         .k_in(pt[BASE]),
         .clk_ev_in(clk_src[c] & ~clk_src_d_r[c]),
         .pre_in(pre),
         .clr_in(clr),
         .load_in(load_vec[c]),
         .load_data_in(load_data[c % 8]),
         .q_out(cell_q[c]),
         .sel_out(cell_sel[c])
      );
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         clk_src_d_r <= '0;
         fb_r <= '0;
      end else begin
         clk_src_d_r <= clk_src;
         fb_r <= cell_sel;
      end
   end

   // pin routing and driver enables
   always_comb begin
      a_nxt = '0;
      b_nxt = '0;
      c_nxt = '0;
      a_oe_nxt = dir_a_in;
      b_oe_nxt = dir_b_in;
      c_oe_nxt = dir_c_in;
      for (int i = 0; i < 8; i++) begin
         if (!omc_cfg_in[i].node_only) begin
            if (!omc_cfg_in[i].alt_port) begin
               a_nxt[i] = cell_sel[i];
               a_oe_nxt[i] = !omc_cfg_in[i].oe_defined || oe_term[i] || dir_a_in[i];
            end else begin
               b_nxt[i] = cell_sel[i];
               b_oe_nxt[i] = !omc_cfg_in[i].oe_defined || oe_term[i] || dir_b_in[i];
            end
         end
         if (!omc_cfg_in[i+8].node_only) begin
            if (omc_cfg_in[i+8].alt_port && plm_pkg::PORT_C_CELLS[i]) begin
               c_nxt[i] = cell_sel[i+8];
               c_oe_nxt[i] = !omc_cfg_in[i+8].oe_defined || oe_term[i+8] || dir_c_in[i];
            end else if (!omc_cfg_in[i+8].alt_port
                         && (omc_cfg_in[i].node_only || !omc_cfg_in[i].alt_port)) begin
               b_nxt[i] = cell_sel[i+8];
               b_oe_nxt[i] = !omc_cfg_in[i+8].oe_defined || oe_term[i+8] || dir_b_in[i];
            end
         end
      end
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         {port_a_out, port_b_out, port_c_out} <= '0;
         {port_a_oe_out, port_b_oe_out, port_c_oe_out} <= '0;
      end else begin
         port_a_out <= a_nxt;
         port_b_out <= b_nxt;
         port_c_out <= c_nxt;
         port_a_oe_out <= a_oe_nxt;
         port_b_oe_out <= b_oe_nxt;
         port_c_oe_out <= c_oe_nxt;
      end
   end

   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!rstn_in);

   sequence s_trailing_ab;
      core_wr_in && hit_ab ##1 !core_wr_in;
   endsequence

   chk_load_wins: assert property (load_vec[0] |=> cell_q[0] == $past(load_data[0]))
      else $error("processor load did not win on first group cell 0");
   chk_mask_blocks: assert property (strobe_ab && mask_ab_r[0] && !g_omc[0].clr && !g_omc[0].pre
      && !(clk_src[0] && !clk_src_d_r[0]) |=> $stable(cell_q[0]))
      else $error("masked first group cell was loaded");
   chk_unmasked_load: assert property (strobe_bc && !mask_bc_r[3]
      |=> cell_q[11] == $past(load_data[3]))
      else $error("unmasked second group cell not loaded");
   chk_edge_load: assert property (load_mode_in == plm_pkg::LOAD_EDGE
      && regsel ##0 s_trailing_ab |-> strobe_ab)
      else $error("trailing write edge did not load");
   chk_level_load: assert property (load_mode_in == plm_pkg::LOAD_LEVEL
      && core_wr_in && hit_ab |-> strobe_ab)
      else $error("level write did not load");
   chk_fs_term: assert property (pt[plm_pkg::PT_FS + 2] |=> primary_flash_sector_selects_out[0])
      else $error("primary sector select missed its third term");
   chk_sram_quiet: assert property (!pt[plm_pkg::PT_SRAM] && !pt[plm_pkg::PT_SRAM + 1]
      |=> !static_ram_select_out)
      else $error("ram select without its terms");
   chk_oe_or_dir: assert property (!omc_cfg_in[0].node_only && !omc_cfg_in[0].alt_port
      && dir_a_in[0] |=> port_a_oe_out[0])
      else $error("direction bit did not enable pin");
   chk_node_free: assert property (omc_cfg_in[1].node_only && !omc_cfg_in[1].alt_port
      |=> port_a_oe_out[1] == $past(dir_a_in[1]) && !port_a_out[1])
      else $error("internal node drove its pin");
   chk_imc_read: assert property (core_rd_in && regsel && core_addr_in[7:0] == plm_pkg::REG_IMC_A
      |=> core_rvalid_out && core_rdata_out == $past(imc_q[7:0]))
      else $error("input cell read returned wrong value");
endmodule // prog_logic

// file: verification/core_model.sv
`timescale 1ns/1ps
module core_model (
   input wire logic clk_in,
   input wire logic [7:0] rdata_in,
   input wire logic rvalid_in,
   output logic [15:0] addr_out,
   output logic [7:0] wdata_out,
   output logic rd_out,
   output logic wr_out
);
   initial begin
      addr_out = 16'h0000;
      wdata_out = 8'h00;
      rd_out = 1'b0;
      wr_out = 1'b0;
   end
   // one strobe cycle; the released data bus shows the inverse of the last value
   task automatic wr_reg(input logic [7:0] off, input logic [7:0] d);
      @(posedge clk_in) #1;
      addr_out = {8'h00, off};
      wdata_out = d;
      wr_out = 1'b1;
      @(posedge clk_in) #1;
      wr_out = 1'b0;
      wdata_out = ~d;
   endtask
   task automatic rd_reg(input logic [7:0] off, output logic [7:0] d);
      int i;
      @(posedge clk_in) #1;
      addr_out = {8'h00, off};
      rd_out = 1'b1;
      @(posedge clk_in) #1;
      rd_out = 1'b0;
      for (i = 0; i < 4 && rvalid_in !== 1'b1; i++) @(posedge clk_in) #1;
      d = rdata_in;
   endtask
endmodule // core_model

// file: verification/programmable_logic_macrocells_tb.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin fails++; \
   $display("Error %s expected %h seen %h", nm, e, g); end end
module programmable_logic_macrocells_tb;
   typedef struct {logic [7:0] wa, wd, ra, ex;} row_s;
   logic clk_in = 1'b0;
   logic rstn_in = 1'b0;
   logic cfg_we = 1'b0;
   plm_pkg::pt_cfg_s cfg_pt = '0;
   plm_pkg::omc_cfg_s [plm_pkg::NUM_OMC-1:0] omc_cfg = '0;
   plm_pkg::imc_cfg_s [plm_pkg::NUM_IMC_GRP-1:0] imc_cfg = '0;
   plm_pkg::load_mode_e load_mode = plm_pkg::LOAD_LEVEL;
   logic [15:0] addr;
   logic [7:0] wdata, rdata, rd_val, pa_out, pa_oe, pb_out;
   logic [7:0] pa_in = 8'h00;
   logic rd, wr, rvalid, regsp;
   logic [7:0] cfg_idx = 8'h00;
   logic [7:0] pb_in = 8'h00;
   logic [7:0] dir_a = 8'h00;
   logic [7:0] dir_b = 8'h00;
   logic [7:0] dir_c = 8'h00;
   logic [7:0] fs, pc_oe;
   logic [3:0] csb;
   logic [2:0] pd_in = 3'h0;
   logic [1:0] psel, ecs;
   logic psen = 1'b0;
   logic ale = 1'b0;
   logic sram;
   int fails = 0;
   int num_checks = 0;
   int cycles = 0;
   row_s rows[7] = '{'{8'h20, 8'h55, 8'h20, 8'h55}, '{8'h21, 8'hA3, 8'h21, 8'hA3},
      '{8'h22, 8'h0F, 8'h22, 8'h0F}, '{8'h20, 8'hFF, 8'h20, 8'hF5},
      '{8'h23, 8'hF0, 8'h23, 8'hF0}, '{8'h21, 8'h0F, 8'h21, 8'hAF},
      '{8'h7F, 8'h11, 8'h7F, 8'h00}};
   always #20 clk_in = ~clk_in;
   core_model core (.clk_in(clk_in), .rdata_in(rdata), .rvalid_in(rvalid), .addr_out(addr),
      .wdata_out(wdata), .rd_out(rd), .wr_out(wr));
   prog_logic dut (.clk_in(clk_in), .rstn_in(rstn_in), .cfg_we_in(cfg_we), .cfg_idx_in(cfg_idx),
      .cfg_pt_in(cfg_pt), .omc_cfg_in(omc_cfg), .imc_cfg_in(imc_cfg), .load_mode_in(load_mode),
      .core_addr_in(addr), .core_wdata_in(wdata), .core_psen_in(psen), .core_rd_in(rd),
      .core_wr_in(wr), .core_ale_in(ale), .core_rst_in(1'b0), .core_pdn_in(1'b0),
      .page_in(8'h00), .flash_ready_in(1'b0), .port_a_in(pa_in), .port_b_in(pb_in),
      .port_c_in(8'h00), .port_d_in(pd_in), .dir_a_in(dir_a), .dir_b_in(dir_b),
      .dir_c_in(dir_c), .core_rdata_out(rdata), .core_rvalid_out(rvalid), .port_a_out(pa_out),
      .port_a_oe_out(pa_oe), .port_b_out(pb_out), .port_b_oe_out(), .port_c_out(),
      .port_c_oe_out(pc_oe), .primary_flash_sector_selects_out(fs),
      .secondary_flash_sector_selects_out(csb), .static_ram_select_out(sram),
      .register_space_select_out(regsp), .peripheral_selects_out(psel),
      .external_chip_selects_out(ecs));
   task automatic final_report;
      $display("checks %0d errors %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // programs one term; lit is the one true literal, or -1 for an always-true term
   task automatic prog_term(input logic [7:0] idx, input int lit);
      @(posedge clk_in) #1;
      cfg_idx = idx;
      cfg_pt.used = 1'b1;
      cfg_pt.true_m = '0;
      if (lit >= 0) cfg_pt.true_m[lit] = 1'b1;
      cfg_we = 1'b1;
      @(posedge clk_in) #1 cfg_we = 1'b0;
   endtask
   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 2000) begin
         fails++;
         final_report();
      end
   end
   initial begin
      for (int i = 0; i < 16; i++) omc_cfg[i].registered = 1'b1;
      repeat (8) @(posedge clk_in);
      #1 rstn_in = 1'b1;
      prog_term(8'h26, -1);
      repeat (2) @(posedge clk_in);
      `CHK("regspace", 1'b1, regsp)
      core.rd_reg(8'h22, rd_val);
      `CHK("mask_ab_rst", 8'h00, rd_val)
      `CHK("rvalid", 1'b1, rvalid)
      core.rd_reg(8'h23, rd_val);
      `CHK("mask_bc_rst", 8'h00, rd_val)
      foreach (rows[i]) begin
         core.wr_reg(rows[i].wa, rows[i].wd);
         core.rd_reg(rows[i].ra, rd_val);
         `CHK("row_read", rows[i].ex, rd_val)
      end
      `CHK("pin_a", 8'hF5, pa_out)
      `CHK("oe_a", 8'hFF, pa_oe)
      `CHK("pin_b", 8'hAF, pb_out)
      core.wr_reg(8'h23, 8'h00);
      load_mode = plm_pkg::LOAD_EDGE;
      core.wr_reg(8'h21, 8'h3C);
      core.rd_reg(8'h21, rd_val);
      `CHK("edge_load", 8'h3C, rd_val)
      core.wr_reg(8'h20, 8'h3C);
      core.rd_reg(8'h20, rd_val);
      `CHK("edge_load_ab", 8'h35, rd_val)
      omc_cfg[3].clk_from_pin = 1'b1;
      omc_cfg[3].invert = 1'b1;
      @(posedge clk_in) #1 pd_in = 3'h2;
      repeat (4) @(posedge clk_in);
      core.rd_reg(8'h20, rd_val);
      `CHK("pin_clock", 8'h3D, rd_val)
      pa_in = 8'h5A;
      pb_in = 8'h3C;
      repeat (4) @(posedge clk_in);
      core.rd_reg(8'h0A, rd_val);
      `CHK("imc_a", 8'h5A, rd_val)
      core.rd_reg(8'h0B, rd_val);
      `CHK("imc_b", 8'h3C, rd_val)
      @(posedge clk_in) #1;
      imc_cfg[0].mode = plm_pkg::IMC_LATCH;
      imc_cfg[0].clk_from_ale = 1'b1;
      ale = 1'b1;
      repeat (2) @(posedge clk_in);
      #1 ale = 1'b0;
      pa_in = 8'hA5;
      repeat (4) @(posedge clk_in);
      core.rd_reg(8'h0A, rd_val);
      `CHK("imc_latch", 8'hAA, rd_val)
      prog_term(8'h02, plm_pkg::IN_PSEN);
      prog_term(8'h19, -1);
      prog_term(8'h25, -1);
      prog_term(8'h28, -1);
      prog_term(8'h29, -1);
      repeat (2) @(posedge clk_in);
      `CHK("fs_idle", 8'h00, fs)
      `CHK("csb", 4'h1, csb)
      `CHK("sram", 1'b1, sram)
      `CHK("psel", 2'h2, psel)
      `CHK("ecs", 2'h1, ecs)
      @(posedge clk_in) #1 psen = 1'b1;
      repeat (2) @(posedge clk_in);
      `CHK("fs_psen", 8'h01, fs)
      @(posedge clk_in) #1;
      omc_cfg[0].oe_defined = 1'b1;
      omc_cfg[1].node_only = 1'b1;
      dir_c = 8'h03;
      repeat (2) @(posedge clk_in);
      `CHK("oe_term", 8'hFC, pa_oe)
      `CHK("oe_c_dir", 8'h03, pc_oe)
      #1 dir_a = 8'h03;
      repeat (2) @(posedge clk_in);
      `CHK("oe_dir", 8'hFF, pa_oe)
      final_report();
   end
endmodule // programmable_logic_macrocells_tb
